/* File: core/ext_master_auto_ack_pkg.sv */
package ext_master_auto_ack_pkg;

    localparam int ADDR_W = 28;
    localparam int WS_W = 4;
    localparam int BEAT_W = 5;
    localparam int CSR_ADDR_W = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CAPTURE = 4'h8;

    // Control field positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_BURST_BIT = 1;
    localparam int CTL_UPPER_ALT_BIT = 2;
    localparam int CTL_WS_LSB = 4;
    localparam int CTL_PORT_LSB = 8;

    // Reset values
    localparam logic CTL_ENABLE_RST = 1'b0;
    localparam logic CTL_BURST_RST = 1'b0;
    localparam logic CTL_UPPER_ALT_RST = 1'b0;
    localparam logic [3:0] CTL_WS_RST = 4'h0;
    localparam logic [1:0] CTL_PORT_RST = 2'h0;

    // Transfer width codes
    localparam logic [1:0] XW_LONG = 2'h0;
    localparam logic [1:0] XW_BYTE = 2'h1;
    localparam logic [1:0] XW_WORD = 2'h2;
    localparam logic [1:0] XW_LINE = 2'h3;

    // Port width codes
    localparam logic [1:0] PW_32 = 2'h0;
    localparam logic [1:0] PW_8 = 2'h1;
    localparam logic [1:0] PW_16 = 2'h2;

    localparam logic [4:0] ONE_BEAT = 5'h01;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DECODE = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_ACK = 5'b01000,
        ST_NEGATE = 5'b10000
    } xfer_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic read;
        logic [1:0] xfer_width_code;
    } xfer_cmd_t;

    typedef struct packed {
        logic auto_ack_external_enable;
        logic burst_enable;
        logic upper_addr_alt;
        logic [WS_W-1:0] wait_count_field;
        logic [1:0] port_width;
    } default_memory_control_t;

    typedef struct packed {
        xfer_state_t st;
        xfer_cmd_t cmd;
        default_memory_control_t ctl;
        logic [BEAT_W-1:0] beats_left;
        logic transfer_ack_n;
        logic ack_oe_n;
        logic waitrequest;
        logic [31:0] readdata;
    } top_state_t;

    typedef struct packed {
        logic [WS_W-1:0] cnt;
    } wait_state_t;

endpackage : ext_master_auto_ack_pkg

/* File: core/wait_state_counter.sv */
`timescale 1ns/1ps
module wait_state_counter #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] count,
    output logic last
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    if (WIDTH < 1) begin : g_width_check
        $error("wait_state_counter: WIDTH must be at least 1");
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_value;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg;
    assign last = (cnt_reg == WIDTH'(1));
endmodule : wait_state_counter

/* File: core/ext_master_auto_ack.sv */
// Function
// - Capture address, direction, width after start
// - Exactly one decode clock before counting
// - Load programmed wait count when enabled
// - Zero waits: acknowledge at third clock
// - Drive negated while count above zero
// - Negate one clock, then release line
// - Zero-wait burst keeps acknowledge asserted
// - Auto acknowledge only outside other regions
// - Never drive address for default memory
// - Upper address bits zero when repurposed
`timescale 1ns/1ps
module ext_master_auto_ack (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic transfer_start_n,
    input wire logic [ext_master_auto_ack_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_read,
    input wire logic [1:0] xfer_width_code,
    input wire logic chip_select_hit,
    input wire logic dram_hit,
    output logic transfer_ack_n,
    output logic transfer_ack_oe_n,
    output logic [ext_master_auto_ack_pkg::ADDR_W-1:0] captured_addr,
    input wire logic [ext_master_auto_ack_pkg::CSR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    ext_master_auto_ack_pkg::top_state_t s_reg;
    ext_master_auto_ack_pkg::top_state_t s_next;
    logic [ext_master_auto_ack_pkg::WS_W-1:0] cnt;
    logic cnt_last;
    logic cnt_load;
    logic take;
    logic csr_req;
    logic [ext_master_auto_ack_pkg::ADDR_W-1:0] addr_masked;

    function automatic logic [4:0] beat_count(input logic [1:0] xw, input logic [1:0] pw,
                                              input logic burst_ok);
        logic [2:0] lb;
        logic [2:0] lp;
        lb = 3'h2;
        lp = 3'h2;
        if (xw == ext_master_auto_ack_pkg::XW_BYTE) lb = 3'h0;
        else if (xw == ext_master_auto_ack_pkg::XW_WORD) lb = 3'h1;
        else if (xw == ext_master_auto_ack_pkg::XW_LINE) lb = 3'h4;
        if (pw == ext_master_auto_ack_pkg::PW_8) lp = 3'h0;
        else if (pw == ext_master_auto_ack_pkg::PW_16) lp = 3'h1;
        // Burst needs burst enable; otherwise one beat only
        if (!burst_ok || lb <= lp) return ext_master_auto_ack_pkg::ONE_BEAT;
        return 5'(ext_master_auto_ack_pkg::ONE_BEAT << (lb - lp));
    endfunction : beat_count

    wait_state_counter #(
        .WIDTH(ext_master_auto_ack_pkg::WS_W)
    ) u_wait (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(cnt_load),
        .load_value(s_reg.ctl.wait_count_field),
        .count(cnt),
        .last(cnt_last)
    );

    // Repurposed upper pins read as zero
    always_comb begin
        addr_masked = bus_addr;
        if (s_reg.ctl.upper_addr_alt) begin
            addr_masked[27:24] = 4'h0;
        end
    end

    assign take = s_reg.ctl.auto_ack_external_enable && !chip_select_hit && !dram_hit;
    assign csr_req = avs_read || avs_write;

    always_comb begin
        s_next = s_reg;
        cnt_load = 1'b0;
        case (s_reg.st)
            ext_master_auto_ack_pkg::ST_IDLE: begin
                s_next.ack_oe_n = 1'b1;
                s_next.transfer_ack_n = 1'b1;
                if (!transfer_start_n) begin
                    s_next.cmd.addr = addr_masked;
                    s_next.cmd.read = bus_read;
                    s_next.cmd.xfer_width_code = xfer_width_code;
                    s_next.st = ext_master_auto_ack_pkg::ST_DECODE;
                end
            end
            ext_master_auto_ack_pkg::ST_DECODE: begin
                s_next.beats_left = beat_count(s_reg.cmd.xfer_width_code,
                                               s_reg.ctl.port_width, s_reg.ctl.burst_enable);
                if (!take) begin
                    s_next.st = ext_master_auto_ack_pkg::ST_IDLE;
                end else if (s_reg.ctl.wait_count_field == '0) begin
                    s_next.transfer_ack_n = 1'b0;
                    s_next.ack_oe_n = 1'b0;
                    s_next.st = ext_master_auto_ack_pkg::ST_ACK;
                end else begin
                    cnt_load = 1'b1;
                    s_next.transfer_ack_n = 1'b1;
                    s_next.ack_oe_n = 1'b0;
                    s_next.st = ext_master_auto_ack_pkg::ST_WAIT;
                end
            end
            ext_master_auto_ack_pkg::ST_WAIT: begin
                if (cnt_last) begin
                    s_next.transfer_ack_n = 1'b0;
                    s_next.st = ext_master_auto_ack_pkg::ST_ACK;
                end
            end
            ext_master_auto_ack_pkg::ST_ACK: begin
                if (s_reg.beats_left > ext_master_auto_ack_pkg::ONE_BEAT) begin
                    s_next.beats_left = s_reg.beats_left - 5'h01;
                    if (s_reg.ctl.wait_count_field == '0) begin
                        s_next.transfer_ack_n = 1'b0;
                    end else begin
                        cnt_load = 1'b1;
                        s_next.transfer_ack_n = 1'b1;
                        s_next.st = ext_master_auto_ack_pkg::ST_WAIT;
                    end
                end else begin
                    s_next.beats_left = '0;
                    s_next.transfer_ack_n = 1'b1;
                    s_next.st = ext_master_auto_ack_pkg::ST_NEGATE;
                end
            end
            ext_master_auto_ack_pkg::ST_NEGATE: begin
                s_next.ack_oe_n = 1'b1;
                s_next.st = ext_master_auto_ack_pkg::ST_IDLE;
            end
            default: begin
                s_next.st = ext_master_auto_ack_pkg::ST_IDLE;
                s_next.ack_oe_n = 1'b1;
                s_next.transfer_ack_n = 1'b1;
            end
        endcase

        // Avalon slave: one wait cycle, then answer
        s_next.waitrequest = 1'b1;
        if (csr_req && s_reg.waitrequest) begin
            s_next.waitrequest = 1'b0;
            s_next.readdata = 32'h0000_0000;
            if (avs_address == ext_master_auto_ack_pkg::OFS_CONTROL) begin
                s_next.readdata[ext_master_auto_ack_pkg::CTL_ENABLE_BIT] =
                    s_reg.ctl.auto_ack_external_enable;
                s_next.readdata[ext_master_auto_ack_pkg::CTL_BURST_BIT] = s_reg.ctl.burst_enable;
                s_next.readdata[ext_master_auto_ack_pkg::CTL_UPPER_ALT_BIT] =
                    s_reg.ctl.upper_addr_alt;
                s_next.readdata[ext_master_auto_ack_pkg::CTL_WS_LSB +: 4] =
                    s_reg.ctl.wait_count_field;
                s_next.readdata[ext_master_auto_ack_pkg::CTL_PORT_LSB +: 2] = s_reg.ctl.port_width;
            end else if (avs_address == ext_master_auto_ack_pkg::OFS_STATUS) begin
                s_next.readdata[4:0] = s_reg.st;
                s_next.readdata[12:8] = s_reg.beats_left;
                s_next.readdata[19:16] = cnt;
                s_next.readdata[24] = s_reg.cmd.read;
                s_next.readdata[26:25] = s_reg.cmd.xfer_width_code;
            end else if (avs_address == ext_master_auto_ack_pkg::OFS_CAPTURE) begin
                s_next.readdata[27:0] = s_reg.cmd.addr;
            end
        end
        if (avs_write && !s_reg.waitrequest &&
            avs_address == ext_master_auto_ack_pkg::OFS_CONTROL) begin
            s_next.ctl.auto_ack_external_enable =
                avs_writedata[ext_master_auto_ack_pkg::CTL_ENABLE_BIT];
            s_next.ctl.burst_enable = avs_writedata[ext_master_auto_ack_pkg::CTL_BURST_BIT];
            s_next.ctl.upper_addr_alt = avs_writedata[ext_master_auto_ack_pkg::CTL_UPPER_ALT_BIT];
            s_next.ctl.wait_count_field = avs_writedata[ext_master_auto_ack_pkg::CTL_WS_LSB +: 4];
            s_next.ctl.port_width = avs_writedata[ext_master_auto_ack_pkg::CTL_PORT_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.st <= ext_master_auto_ack_pkg::ST_IDLE;
            s_reg.cmd <= '0;
            s_reg.ctl.auto_ack_external_enable <= ext_master_auto_ack_pkg::CTL_ENABLE_RST;
            s_reg.ctl.burst_enable <= ext_master_auto_ack_pkg::CTL_BURST_RST;
            s_reg.ctl.upper_addr_alt <= ext_master_auto_ack_pkg::CTL_UPPER_ALT_RST;
            s_reg.ctl.wait_count_field <= ext_master_auto_ack_pkg::CTL_WS_RST;
            s_reg.ctl.port_width <= ext_master_auto_ack_pkg::CTL_PORT_RST;
            s_reg.beats_left <= '0;
            s_reg.transfer_ack_n <= 1'b1;
            s_reg.ack_oe_n <= 1'b1;
            s_reg.waitrequest <= 1'b1;
            s_reg.readdata <= 32'h0000_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    // The only address output is captured_addr, which is not driven onto the bus; the master supplies every address
    assign transfer_ack_n = s_reg.transfer_ack_n;
    assign transfer_ack_oe_n = s_reg.ack_oe_n;
    assign captured_addr = s_reg.cmd.addr;
    assign avs_readdata = s_reg.readdata;
    assign avs_waitrequest = s_reg.waitrequest;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence start_seen;
        s_reg.st == ext_master_auto_ack_pkg::ST_IDLE && !transfer_start_n;
    endsequence

    sequence decode_taken_zero;
        s_reg.st == ext_master_auto_ack_pkg::ST_DECODE && take &&
            s_reg.ctl.wait_count_field == 4'h0;
    endsequence

    a_capture_cmd: assert property (start_seen |=> captured_addr == $past(addr_masked)
        && s_reg.cmd.read == $past(bus_read))
        else $error("captured command differs from bus");
    a_one_decode: assert property (start_seen |=>
        s_reg.st == ext_master_auto_ack_pkg::ST_DECODE ##1
        s_reg.st != ext_master_auto_ack_pkg::ST_DECODE)
        else $error("decode did not last exactly one clock");
    a_wait_load: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_DECODE && take &&
        s_reg.ctl.wait_count_field != 4'h0 |=> cnt == $past(s_reg.ctl.wait_count_field))
        else $error("wait counter not loaded with programmed count");
    a_zero_wait_ack: assert property (start_seen ##1 decode_taken_zero |=>
        !transfer_ack_n && !transfer_ack_oe_n)
        else $error("acknowledge missing in third clock");
    a_wait_negated: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_WAIT |->
        transfer_ack_n && !transfer_ack_oe_n)
        else $error("acknowledge not driven negated during wait");
    a_release_seq: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_ACK &&
        s_reg.beats_left == 5'h01 |=> (transfer_ack_n && !transfer_ack_oe_n) ##1
        transfer_ack_oe_n)
        else $error("acknowledge not negated then released");
    a_burst_hold: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_ACK &&
        s_reg.beats_left > 5'h01 && s_reg.ctl.wait_count_field == 4'h0 |=> !transfer_ack_n)
        else $error("zero-wait burst dropped acknowledge");
    a_region_skip: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_DECODE &&
        (chip_select_hit || dram_hit) |=> transfer_ack_oe_n [*2])
        else $error("acknowledge driven for another region");
    a_upper_zero: assert property ((start_seen and s_reg.ctl.upper_addr_alt) |=>
        captured_addr[27:24] == 4'h0)
        else $error("upper address bits not zeroed");
    a_disabled_hiz: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_DECODE &&
        !s_reg.ctl.auto_ack_external_enable |=> transfer_ack_oe_n)
        else $error("acknowledge driven while disabled");
    a_count_ack: assert property (s_reg.st == ext_master_auto_ack_pkg::ST_WAIT && cnt_last
        |=> !transfer_ack_n)
        else $error("acknowledge not given after count expired");
    a_state_onehot: assert property ($onehot(s_reg.st))
        else $error("transfer state not one-hot");
endmodule : ext_master_auto_ack

/* File: sim/ext_master_model.sv */
`timescale 1ns/1ps
module ext_master_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [27:0] go_addr,
    input wire logic go_read,
    input wire logic [1:0] go_width,
    input wire logic [4:0] n_beats,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe_n,
    output logic transfer_start_n,
    output logic [27:0] bus_addr,
    output logic bus_read,
    output logic [1:0] xfer_width_code,
    output logic busy,
    output logic [7:0] first_lat,
    output logic [7:0] last_lat,
    output logic data_drive
);
    logic [7:0] cnt;
    logic [4:0] got;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_start_n <= 1'b1;
            bus_addr <= 28'h0;
            bus_read <= 1'b1;
            xfer_width_code <= 2'h0;
            busy <= 1'b0;
            cnt <= 8'h0;
            got <= 5'h0;
            first_lat <= 8'h0;
            last_lat <= 8'h0;
            data_drive <= 1'b0;
        end else if (go && !busy) begin
            transfer_start_n <= 1'b0;
            bus_addr <= go_addr;
            bus_read <= go_read;
            xfer_width_code <= go_width;
            data_drive <= 1'b0;
            busy <= 1'b1;
            cnt <= 8'h0;
            got <= 5'h0;
        end else if (busy) begin
            // Start lasts one clock only
            transfer_start_n <= 1'b1;
            cnt <= cnt + 8'h1;
            // Write data from the second clock through every wait
            data_drive <= !bus_read && n_beats != 5'h0;
            if (n_beats == 5'h0) begin
                busy <= 1'b0;
            end else if (!transfer_ack_oe_n && !transfer_ack_n) begin
                // Beat ends on acknowledge; next address is ours to supply
                got <= got + 5'h1;
                bus_addr <= bus_addr + 28'h1;
                if (got == 5'h0) first_lat <= cnt + 8'h1;
                last_lat <= cnt + 8'h1;
                if (got + 5'h1 == n_beats) begin
                    busy <= 1'b0;
                    data_drive <= 1'b0;
                end
            end
        end else begin
            // Released lines show no stale value
            bus_addr <= ~bus_addr;
            bus_read <= ~bus_read;
        end
    end
endmodule : ext_master_model

/* File: sim/tb_ext_master_auto_ack.sv */
`timescale 1ns/1ps
module tb_ext_master_auto_ack;
    logic ref_clk, rst_n, go, go_read, tstart_n, b_read, cs_hit, dram_hit, ack_n, ack_oe_n;
    logic [27:0] go_addr, b_addr, cap_addr;
    logic [1:0] go_width, b_width;
    logic [4:0] n_beats;
    logic [7:0] first_lat, last_lat;
    logic m_busy, avs_read, avs_write, avs_waitrequest, data_drive;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int fails, n_checks;

    ext_master_auto_ack dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .transfer_start_n(tstart_n),
        .bus_addr(b_addr), .bus_read(b_read), .xfer_width_code(b_width),
        .chip_select_hit(cs_hit), .dram_hit(dram_hit), .transfer_ack_n(ack_n),
        .transfer_ack_oe_n(ack_oe_n), .captured_addr(cap_addr), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    ext_master_model master_u (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .go_addr(go_addr),
        .go_read(go_read), .go_width(go_width), .n_beats(n_beats), .transfer_ack_n(ack_n),
        .transfer_ack_oe_n(ack_oe_n), .transfer_start_n(tstart_n), .bus_addr(b_addr),
        .bus_read(b_read), .xfer_width_code(b_width), .busy(m_busy),
        .first_lat(first_lat), .last_lat(last_lat), .data_drive(data_drive));

    always #2.5 ref_clk = ~ref_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 20) begin
            fails++;
            final_report();
        end
    endtask : bus

    task automatic run(input logic [27:0] a, input logic r, input logic [1:0] w,
                       input int beats, input int ws);
        int i;
        @(posedge ref_clk);
        go <= 1'b1;
        go_addr <= a;
        go_read <= r;
        go_width <= w;
        n_beats <= beats[4:0];
        @(posedge ref_clk);
        go <= 1'b0;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            #1;
            if (beats == 0) chk("oe_n idle", 32'h1, {31'h0, ack_oe_n});
            if (beats != 0 && !r && i == 0) chk("data driven", 32'h1, {31'h0, data_drive});
            if (beats == 0 && i == 8) break;
            if (beats != 0 && m_busy === 1'b0) break;
        end
        if (i == 200) begin
            fails++;
            final_report();
        end
        if (beats != 0) begin
            chk("first ack", 32'(3 + ws), {24'h0, first_lat});
            chk("last ack", 32'(3 + ws + (beats - 1) * (ws + 1)), {24'h0, last_lat});
            chk("negate ack_n", 32'h1, {31'h0, ack_n});
            chk("negate oe_n", 32'h0, {31'h0, ack_oe_n});
            if (!r) chk("data released", 32'h0, {31'h0, data_drive});
            @(posedge ref_clk);
            #1;
            chk("release oe_n", 32'h1, {31'h0, ack_oe_n});
        end
    endtask : run

    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0);
        chk("control reset", 32'h0, rd);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped read", 32'h0, rd);
        bus(1'b1, 4'h0, 32'h0000_02f7);
        bus(1'b0, 4'h0, 32'h0);
        chk("control readback", 32'h0000_02f7, rd);
        $display("test regs done");
    endtask : t_regs

    task automatic t_refused();
        bus(1'b1, 4'h0, 32'h0);
        run(28'h000_0100, 1'b1, 2'h0, 0, 0);
        bus(1'b1, 4'h0, 32'h0000_0001);
        cs_hit <= 1'b1;
        run(28'h000_0200, 1'b1, 2'h0, 0, 0);
        cs_hit <= 1'b0;
        dram_hit <= 1'b1;
        run(28'h000_0300, 1'b0, 2'h0, 0, 0);
        dram_hit <= 1'b0;
        $display("test refused done");
    endtask : t_refused

    task automatic t_single();
        run(28'hf00_0040, 1'b1, 2'h0, 1, 0);
        chk("captured", 32'h0f00_0040, {4'h0, cap_addr});
        bus(1'b1, 4'h0, 32'h0000_0031);
        run(28'h000_0080, 1'b0, 2'h0, 1, 3);
        run(28'h000_0084, 1'b1, 2'h1, 1, 3);
        $display("test single done");
    endtask : t_single

    task automatic t_burst();
        bus(1'b1, 4'h0, 32'h0000_0103);
        run(28'h000_1000, 1'b1, 2'h0, 4, 0);
        bus(1'b1, 4'h0, 32'h0000_0023);
        run(28'h000_2000, 1'b1, 2'h3, 4, 2);
        bus(1'b1, 4'h0, 32'h0000_0101);
        run(28'h000_3000, 1'b1, 2'h0, 1, 0);
        bus(1'b1, 4'h0, 32'h0000_0213);
        run(28'h000_4000, 1'b1, 2'h0, 2, 1);
        run(28'h000_4010, 1'b0, 2'h1, 1, 1);
        run(28'h000_4020, 1'b1, 2'h2, 1, 1);
        run(28'h000_4040, 1'b1, 2'h3, 8, 1);
        $display("test burst done");
    endtask : t_burst

    task automatic t_upper();
        bus(1'b1, 4'h0, 32'h0000_0005);
        run(28'hf12_3456, 1'b1, 2'h0, 1, 0);
        chk("captured masked", 32'h0012_3456, {4'h0, cap_addr});
        bus(1'b0, 4'h8, 32'h0);
        chk("capture reg", 32'h0012_3456, rd);
        bus(1'b0, 4'h4, 32'h0);
        chk("status idle", 32'h0100_0001, rd);
        $display("test upper done");
    endtask : t_upper

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        go = 1'b0;
        go_addr = 28'h0;
        go_read = 1'b1;
        go_width = 2'h0;
        n_beats = 5'h0;
        cs_hit = 1'b0;
        dram_hit = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_refused();
        t_single();
        t_burst();
        t_upper();
        final_report();
    end
endmodule : tb_ext_master_auto_ack
